/* File: logic/dirf_params.svh */
// Offsets, field positions and reset values of the interrupt routing fabric
`ifndef DIRF_PARAMS_SVH
`define DIRF_PARAMS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define DIRF_OFS_CTRL        8'h00
`define DIRF_OFS_POLARITY    8'h04
`define DIRF_OFS_STATUS      8'h08
`define DIRF_OFS_ROUTE       8'h0C

// ****************************************
// Control register fields
// ****************************************
`define DIRF_CTRL_BYPASS_BIT   0
`define DIRF_CTRL_CASCADE_BIT  1
`define DIRF_CTRL_NOINV_BIT    2
`define DIRF_CTRL_CFG_LSB      4
`define DIRF_CTRL_CFG_MSB      6

// ****************************************
// Reset values
// ****************************************
`define DIRF_RST_BYPASS      1'b1
`define DIRF_RST_CASCADE     1'b0
`define DIRF_RST_NOINV       1'b0
`define DIRF_RST_CFG         3'h3
`define DIRF_RST_POLARITY    16'h0000

// ****************************************
// Configuration codes and line numbers
// ****************************************
`define DIRF_CFG_FIRST       3'h1
`define DIRF_CFG_LAST        3'h7
`define DIRF_CFG_NO_TIMER    3'h2
`define DIRF_CFG_MCA_INTEG   3'h7
`define DIRF_NUM_IO_INPUTS   16
`define DIRF_NUM_CPUS        2
`define DIRF_LINE_TIMER      2
`define DIRF_LINE_CHAIN      13

`endif

/* File: logic/dirf_pkg.sv */
// Types shared by the interrupt routing fabric
`default_nettype none
package dirf_pkg;

    typedef enum logic [1:0]
    {
        DIRF_BUS_ISA  = 2'h0,
        DIRF_BUS_EISA = 2'h1,
        DIRF_BUS_MCA  = 2'h3
    } dirf_bus_e;

    // Synchronised input lines
    typedef struct packed
    {
        logic        lu_nmi;
        logic        lu_intr;
        logic        nmi;
        logic        pic_intr;
        logic [15:0] irq;
    } dirf_lines_s;

    // Routed outputs
    typedef struct packed
    {
        logic        boot_nmi;
        logic        boot_intr;
        logic [1:0]  local_one;
        logic [1:0]  local_zero;
        logic [15:0] io_in;
    } dirf_route_s;

endpackage

`default_nettype wire

/* File: logic/dirf_top.sv */
// Interrupt routing fabric of a default dual-processor system, AHB-Lite registers
//
// The AHB-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "dirf_params.svh"

module dirf_top
(
    input  wire logic        core_clk_i,
    input  wire logic        reset_n_i,
    // AHB-Lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    // Interrupt sources, asynchronous pins
    input  wire logic [15:0] irq_i,
    input  wire logic        pic_intr_i,
    input  wire logic        nmi_i,
    input  wire logic        lu_boot_intr_i,
    input  wire logic        lu_boot_nmi_i,
    // Routed interrupts
    output logic      [15:0] io_unit_input_n_o,
    output logic      [1:0]  local_input_zero_o,
    output logic      [1:0]  local_input_one_o,
    output logic             boot_processor_intr_o,
    output logic             boot_processor_nmi_o
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    dirf_pkg::dirf_lines_s meta_q;
    dirf_pkg::dirf_lines_s sync_q;
    dirf_pkg::dirf_lines_s raw_in;

    assign raw_in = '{lu_nmi: lu_boot_nmi_i, lu_intr: lu_boot_intr_i,
                      nmi: nmi_i, pic_intr: pic_intr_i, irq: irq_i};

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= raw_in;
            sync_q <= meta_q;
        end
    end

    // ****************************************
    // AHB-Lite slave
    // ****************************************
    logic        wr_pend_q;
    logic [7:0]  addr_q;
    logic        bypass_q;
    logic        cascade_q;
    logic        noinv_q;
    logic [2:0]  cfg_q;
    logic [15:0] polarity_q;

    wire         take_req   = hsel_i && htrans_i[1] && hready_i;
    wire         wr_ctrl    = wr_pend_q && (addr_q == `DIRF_OFS_CTRL);
    wire         wr_pol     = wr_pend_q && (addr_q == `DIRF_OFS_POLARITY);
    wire  [2:0]  cfg_wdata  = hwdata_i[`DIRF_CTRL_CFG_MSB:`DIRF_CTRL_CFG_LSB];
    // Reserved code 0 would leave the wiring undefined, so it is dropped
    wire         cfg_ok     = (cfg_wdata >= `DIRF_CFG_FIRST) && (cfg_wdata <= `DIRF_CFG_LAST);

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            wr_pend_q <= 1'b0;
            addr_q    <= 8'h00;
        end
        else
        begin
            wr_pend_q <= take_req && hwrite_i;
            if (take_req)
            begin
                addr_q <= {haddr_i[7:2], 2'b00};
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            bypass_q   <= `DIRF_RST_BYPASS;
            cascade_q  <= `DIRF_RST_CASCADE;
            noinv_q    <= `DIRF_RST_NOINV;
            cfg_q      <= `DIRF_RST_CFG;
            polarity_q <= `DIRF_RST_POLARITY;
        end
        else
        begin
            if (wr_ctrl)
            begin
                bypass_q  <= hwdata_i[`DIRF_CTRL_BYPASS_BIT];
                cascade_q <= hwdata_i[`DIRF_CTRL_CASCADE_BIT];
                noinv_q   <= hwdata_i[`DIRF_CTRL_NOINV_BIT];
            end
            if (wr_ctrl && cfg_ok)
            begin
                cfg_q <= cfg_wdata;
            end
            if (wr_pol)
            begin
                polarity_q <= hwdata_i[15:0];
            end
        end
    end

    // ****************************************
    // Bus type of the chosen configuration
    // ****************************************
    dirf_pkg::dirf_bus_e bus_type;

    always_comb
    begin
        case (cfg_q)
            3'h1, 3'h5: bus_type = dirf_pkg::DIRF_BUS_ISA;
            3'h2, 3'h3, 3'h6: bus_type = dirf_pkg::DIRF_BUS_EISA;
            3'h4, 3'h7: bus_type = dirf_pkg::DIRF_BUS_MCA;
            default: bus_type = dirf_pkg::DIRF_BUS_ISA;
        endcase
    end

    wire is_eisa = (bus_type == dirf_pkg::DIRF_BUS_EISA);
    wire is_mca  = (bus_type == dirf_pkg::DIRF_BUS_MCA);
    wire no_tmr  = (cfg_q == `DIRF_CFG_NO_TIMER);
    // Config 7 has no PIC wire to input 0, so cascade-through cannot reopen it
    wire no_pic0 = (cfg_q == `DIRF_CFG_MCA_INTEG);

    // ****************************************
    // I/O unit input wiring, one slice per input
    // ****************************************
    dirf_pkg::dirf_route_s route_d;
    dirf_pkg::dirf_route_s route_q;

    genvar n;
    generate
        for (n = 0; n < `DIRF_NUM_IO_INPUTS; n = n + 1)
        begin : g_io
            // Input 0 is the PIC, input 2 the timer on IRQ0, the rest IRQn
            localparam int SRC = (n == `DIRF_LINE_TIMER) ? 0 : n;
            wire src_line;
            wire invert;
            wire open_line;
            if (n == 0)
            begin : g_pic
                // Cascade-through keeps the PIC on input 0; masked PIC gives chaining only
                assign src_line  = sync_q.pic_intr;
                assign invert    = 1'b0;
                assign open_line = no_pic0;
            end
            else
            begin : g_irq
                // IRQ13 is wired as the chaining line only, no FPU error
                assign src_line  = sync_q.irq[SRC];
                assign invert    = !noinv_q &&
                                   ((is_eisa && polarity_q[SRC]) || is_mca);
                assign open_line = no_tmr &&
                                   (n == `DIRF_LINE_TIMER || n == `DIRF_LINE_CHAIN);
            end
            assign route_d.io_in[n] = !open_line && (src_line ^ invert);
        end
    endgenerate

    // ****************************************
    // Local units and boot processor muxes
    // ****************************************
    assign route_d.local_zero = {`DIRF_NUM_CPUS{sync_q.pic_intr}};
    assign route_d.local_one  = {`DIRF_NUM_CPUS{sync_q.nmi}};
    // Both muxes share one select so INTR and NMI never split paths
    assign route_d.boot_intr  = bypass_q ? sync_q.pic_intr : sync_q.lu_intr;
    assign route_d.boot_nmi   = bypass_q ? sync_q.nmi : sync_q.lu_nmi;

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            route_q <= '0;
        end
        else
        begin
            route_q <= route_d;
        end
    end

    assign io_unit_input_n_o     = route_q.io_in;
    assign local_input_zero_o    = route_q.local_zero;
    assign local_input_one_o     = route_q.local_one;
    assign boot_processor_intr_o = route_q.boot_intr;
    assign boot_processor_nmi_o  = route_q.boot_nmi;

    // ****************************************
    // Read data
    // ****************************************
    // Muxed from flops in the data phase so a read right after a write sees it
    wire [31:0] rd_ctrl   = {25'h0000000, cfg_q, 1'b0, noinv_q, cascade_q, bypass_q};
    wire [31:0] rd_pol    = {16'h0000, polarity_q};
    wire [31:0] rd_status = {14'h0000, sync_q.nmi, sync_q.pic_intr, sync_q.irq};
    wire [31:0] rd_route  = {10'h000, route_q};

    assign hrdata_o = (addr_q == `DIRF_OFS_CTRL)     ? rd_ctrl   :
                      (addr_q == `DIRF_OFS_POLARITY) ? rd_pol    :
                      (addr_q == `DIRF_OFS_STATUS)   ? rd_status :
                      (addr_q == `DIRF_OFS_ROUTE)    ? rd_route  : 32'h00000000;

    // Zero wait states, always OKAY
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

    wire unused_ok = &{1'b0, hsize_i, haddr_i[31:8], haddr_i[1:0]};

endmodule

`default_nettype wire

/* File: verif/dirf_far_model.sv */
// Model of the legacy PIC and the boot processor local unit
`timescale 1ns/1ps
`default_nettype none
module dirf_far_model
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [15:0] irq_i,
    input  wire logic        mask_i,
    input  wire logic [2:0]  cpu_i,
    output logic             pic_intr_o,
    output logic             nmi_o,
    output logic             lu_intr_o,
    output logic             lu_nmi_o
);
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pic_intr_o <= 1'b0;
            nmi_o      <= 1'b0;
            lu_intr_o  <= 1'b0;
            lu_nmi_o   <= 1'b0;
        end
        else
        begin
            // Masked PIC passes only the chaining request
            pic_intr_o <= mask_i ? irq_i[13] : |irq_i;
            nmi_o      <= cpu_i[0];
            // Local inputs only used in symmetric mode
            lu_intr_o  <= cpu_i[1];
            lu_nmi_o   <= cpu_i[2];
        end
    end
endmodule
`default_nettype wire

/* File: verif/dirf_top_assertions.sv */
// Port checker of the interrupt routing fabric
`timescale 1ns/1ps
`default_nettype none
module dirf_top_assertions
(
    input  wire logic        core_clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic        hready_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic [31:0] hrdata_o,
    input  wire logic        hreadyout_o,
    input  wire logic        hresp_o,
    input  wire logic        pic_intr_i,
    input  wire logic        nmi_i,
    input  wire logic        lu_boot_intr_i,
    input  wire logic        lu_boot_nmi_i,
    input  wire logic [15:0] io_unit_input_n_o,
    input  wire logic [1:0]  local_input_zero_o,
    input  wire logic [1:0]  local_input_one_o,
    input  wire logic        boot_processor_intr_o,
    input  wire logic        boot_processor_nmi_o
);
    logic [1:0] up_q;
    logic       rd_q;
    logic [5:0] ad_q;
    logic       wc_q;
    logic       byp_q;
    wire        ok = up_q == 2'h3;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    // Path checks wait out the three-flop input latency after reset
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            up_q <= 2'h0;
            rd_q <= 1'b0;
            ad_q <= 6'h00;
            wc_q <= 1'b0;
            byp_q <= 1'b1;
        end
        else
        begin
            up_q <= ok ? up_q : up_q + 2'h1;
            rd_q <= hsel_i & htrans_i[1] & hready_i & !hwrite_i;
            ad_q <= haddr_i[7:2];
            // Shadow of the bypass bit, committed at the write data phase edge
            wc_q <= hsel_i & htrans_i[1] & hready_i & hwrite_i & (haddr_i[7:2] == 6'h00);
            byp_q <= wc_q ? hwdata_i[0] : byp_q;
        end
    end
    a_resp_okay: assert property (hresp_o == 1'b0 && hreadyout_o == 1'b1)
        else $error("bus response not OKAY zero wait");
    a_local_zero: assert property (ok |->
        local_input_zero_o == {2{$past(pic_intr_i, 3)}})
        else $error("local input zero not PIC request");
    a_local_one: assert property (ok |-> local_input_one_o == {2{$past(nmi_i, 3)}})
        else $error("local input one not NMI");
    a_boot_pair: assert property (ok |->
        {boot_processor_intr_o, boot_processor_nmi_o} == ($past(byp_q) ?
        {$past(pic_intr_i, 3), $past(nmi_i, 3)} :
        {$past(lu_boot_intr_i, 3), $past(lu_boot_nmi_i, 3)}))
        else $error("boot outputs not on the selected path");
    a_io_zero: assert property (ok && io_unit_input_n_o[0] |-> $past(pic_intr_i, 3))
        else $error("input zero high without PIC request");
    a_route_mirror: assert property (rd_q && ad_q == 6'h03 |->
        hrdata_o[15:0] == io_unit_input_n_o)
        else $error("route read differs from inputs");
    a_status_unused: assert property (rd_q && ad_q == 6'h02 |-> hrdata_o[31:18] == 14'h0000)
        else $error("status upper bits not zero");
    a_unmapped_zero: assert property (rd_q && ad_q > 6'h03 |-> hrdata_o == 32'h00000000)
        else $error("unmapped read not zero");
    a_ctrl_unused: assert property (rd_q && ad_q == 6'h00 |->
        hrdata_o[31:7] == 25'h0 && !hrdata_o[3])
        else $error("control unused bits not zero");
endmodule
bind dirf_top dirf_top_assertions chk_u (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hready_i(hready_i), .hwdata_i(hwdata_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o),
    .pic_intr_i(pic_intr_i), .nmi_i(nmi_i), .lu_boot_intr_i(lu_boot_intr_i),
    .lu_boot_nmi_i(lu_boot_nmi_i), .io_unit_input_n_o(io_unit_input_n_o),
    .local_input_zero_o(local_input_zero_o), .local_input_one_o(local_input_one_o),
    .boot_processor_intr_o(boot_processor_intr_o), .boot_processor_nmi_o(boot_processor_nmi_o));
`default_nettype wire

/* File: verif/dirf_top_tb.sv */
// Self-checking testbench of the interrupt routing fabric
`timescale 1ns/1ps
`default_nettype none
module dirf_top_tb;
    logic        clk, rst_n, hsel, hwrite, hrdy, hresp, msk, pic, nmi, lui, lun, bi, bn, p;
    logic [1:0]  htrans, lz, lo, bx;
    logic [2:0]  cpu;
    logic [15:0] irq, io, pol, e;
    logic [31:0] haddr, hwdata, hrdata, rd, c;
    int          error_cnt, checks, cyc;
    dirf_top dut_u (.core_clk_i(clk), .reset_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
        .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp), .irq_i(irq), .pic_intr_i(pic),
        .nmi_i(nmi), .lu_boot_intr_i(lui), .lu_boot_nmi_i(lun), .io_unit_input_n_o(io),
        .local_input_zero_o(lz), .local_input_one_o(lo), .boot_processor_intr_o(bi),
        .boot_processor_nmi_o(bn));
    dirf_far_model far_u (.clk_i(clk), .rst_n_i(rst_n), .irq_i(irq), .mask_i(msk), .cpu_i(cpu),
        .pic_intr_o(pic), .nmi_o(nmi), .lu_intr_o(lui), .lu_nmi_o(lun));
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            error_cnt++;
            stop_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checks++;
        if (got !== ex)
        begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge clk); while (hrdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hrdy !== 1'b1);
        rd = hrdata;
    endtask
    function automatic logic [15:0] exp_io(input logic [15:0] q, input logic pc,
        input logic [31:0] ct, input logic [15:0] pl);
        logic [15:0] v;
        logic [2:0]  g;
        g = ct[6:4];
        v = q;
        v[0] = pc;
        v[2] = q[0];
        for (int n = 1; n < 16; n++)
        begin
            if (!ct[2] && (g == 3'h2 || g == 3'h3 || g == 3'h6) && pl[(n == 2) ? 0 : n])
                v[n] = ~v[n];
            if (!ct[2] && (g == 3'h4 || g == 3'h7))
                v[n] = ~v[n];
        end
        if (g == 3'h2)
        begin
            v[2] = 1'b0;
            v[13] = 1'b0;
        end
        if (g == 3'h7)
            v[0] = 1'b0;
        return v;
    endfunction
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        {hsel, hwrite, htrans, haddr, hwdata, irq, msk, cpu, rst_n, cyc} = '0;
        error_cnt = 0;
        checks = 0;
        c = $urandom(32'hD732B996);
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        bus(1'b0, 32'h0, 32'h0);
        chk("ctrl", 32'h31, rd);
        bus(1'b0, 32'h4, 32'h0);
        chk("polarity", 32'h0, rd);
        bus(1'b1, 32'h40, 32'hFFFFFFFF);
        bus(1'b0, 32'h40, 32'h0);
        chk("unmapped", 32'h0, rd);
        bus(1'b1, 32'h0, 32'h37);
        bus(1'b1, 32'h0, 32'h2);
        bus(1'b0, 32'h0, 32'h0);
        chk("ctrl_cfg_keep", 32'h32, rd);
        $display("test registers done");
        for (int i = 0; i < 56; i++)
        begin
            c = {25'h0, 3'(i % 7 + 1), 1'b0, 3'($urandom)};
            // Without the chaining line software picks cascade-through
            if (c[6:4] == 3'h2)
                c[1] = 1'b1;
            pol = 16'($urandom);
            bus(1'b1, 32'h4, {16'h0, pol});
            bus(1'b1, 32'h0, c);
            irq <= (i < 7) ? 16'hFFFF : 16'($urandom);
            msk <= 1'($urandom);
            cpu <= 3'($urandom);
            repeat (6) @(posedge clk);
            p = msk ? irq[13] : |irq;
            e = exp_io(irq, p, c, pol);
            chk("io_inputs", {16'h0, e}, {16'h0, io});
            chk("local_zero", {30'h0, {2{p}}}, {30'h0, lz});
            chk("local_one", {30'h0, {2{cpu[0]}}}, {30'h0, lo});
            bx = c[0] ? {p, cpu[0]} : {cpu[1], cpu[2]};
            chk("boot", {30'h0, bx}, {30'h0, bi, bn});
            bus(1'b0, 32'hC, 32'h0);
            chk("route", {16'h0, e}, {16'h0, rd[15:0]});
            bus(1'b0, 32'h8, 32'h0);
            chk("status", {14'h0, cpu[0], p, irq}, rd);
        end
        $display("test routing done");
        stop_test();
    end
endmodule
`default_nettype wire
